// ==== wake_timer_pkg.sv ====
// Constants and types shared by the interval timer and wake status block.
package wake_timer_pkg;
  localparam int CNT_W = 6;
  localparam int SEL_W = 3;
  localparam int OPND_W = 9;
  localparam int TAP_N = 7;
  localparam int PA_W = 4;
  localparam logic [5:0] CNT_ZERO = 6'h00;
  localparam logic [5:0] CNT_WRAP = 6'h3F;
  // Tap order on the tap input port.
  localparam int TAP3 = 0;
  localparam int TAP5 = 1;
  localparam int TAP7 = 2;
  localparam int TAP9 = 3;
  localparam int TAP11 = 4;
  localparam int TAP13 = 5;
  localparam int TAP15 = 6;
  // Oscillator periods per tick for the fastest and slowest taps.
  localparam int TAP3_PERIODS = 8;
  localparam int TAP15_PERIODS = 32768;
  // Operand fields.
  localparam int SEL_LSB = 6;
  localparam logic [8:0] OPND_RELOAD = 9'h001;
  localparam logic [8:0] OPND_CARRY = 9'h001;
  localparam logic [8:0] OPND_BACKUP = 9'h002;
  localparam int REQ_STOP_BIT = 0;
  localparam int REQ3_BIT = 3;
  localparam int REQ4_BIT = 4;
  localparam int HALT_RELEASE_ENABLE_3_BIT = 3;
  localparam int HALT_RELEASE_ENABLE_4_BIT = 4;
  localparam int SEF5_BIT = 5;
  localparam int PORT_STOP_RELEASE_ENABLE_BIT = 6;
  // Status bit positions.
  localparam int CF_BIT = 3;
  localparam int NIL_BIT = 2;
  localparam int NONPORT_BIT = 2;
  localparam int BACKUP_BIT = 0;
  localparam int PDWAKE_BIT = 3;
  localparam int TAP15_BIT = 2;
  localparam int PWAKE_BIT = 2;
  localparam int TWAKE_BIT = 1;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] PA_ALL_INPUT = 4'hF;

  typedef enum logic [4:0] {
    NO_OP, TIMER_LOAD_IMM_OP, TIMER_LOAD_REG_OP, RELOAD_ENABLE_OP,
    RELOAD_DISABLE_OP, SET_FLAG_OP, CLEAR_FLAG_OP, READ_ARITH_STATUS_OP,
    WRITE_ARITH_STATUS_OP, READ_BACKUP_STATUS_OP, READ_PREDIVIDER_STATUS_OP,
    READ_WAKE_SOURCE_OP, SWITCH_CONFIG_OP, HALT_RELEASE_CONFIG_OP,
    STOP_RELEASE_CONFIG_OP, CLEAR_REQUEST_OP, HALT_OP, STOP_OP
  } op_e;

  typedef enum logic [1:0] {PWR_RUN, PWR_HALT, PWR_STOP} pwr_e;
endpackage

// ==== edge_sync.sv ====
// Two-stage synchroniser with edge detection for a group of pins.
`timescale 1ns/1ns
module edge_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst,
  // Asynchronous pins.
  input  wire logic [WIDTH-1:0] pin,
  // Synchronised level and edges.
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] prev;
    logic             armed;
  } sync_s;

  sync_s s_r;
  sync_s s_nxt;

  // Only the second stage reads the first, so metastability stays put.
  // The stages keep tracking the pins through reset, so a pin that is high
  // at release is not reported as a fresh edge against a cleared history.
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin;
    s_nxt.s2 = s_r.s1;
    s_nxt.prev = s_r.s2;
    s_nxt.armed = !rst;
  end

  always_ff @(posedge mclk) begin
    s_r <= s_nxt;
  end

  // Edges compare the settled stage with its own history, masked in reset.
  assign lvl = s_r.s2;
  assign rise = {WIDTH{s_r.armed}} & s_r.s2 & ~s_r.prev;
  assign fall = {WIDTH{s_r.armed}} & ~s_r.s2 & s_r.prev;
endmodule

// ==== wake_timer.sv ====
// Interval timer with status and start condition flags facing the core.
`timescale 1ns/1ns
module wake_timer (
  // Clock and reset.
  input  wire logic                               mclk,
  input  wire logic                               rst,
  // Operation strobe from the core.
  input  wire logic                               op_valid,
  input  wire wake_timer_pkg::op_e                op_code,
  input  wire logic [wake_timer_pkg::OPND_W-1:0]  op_imm,
  input  wire logic [3:0]                         acc_in,
  input  wire logic [3:0]                         rx_in,
  input  wire logic [3:0]                         ram_in,
  // Carry from the arithmetic unit.
  input  wire logic                               alu_carry_we,
  input  wire logic                               alu_carry,
  // Interrupt acceptance ends halt.
  input  wire logic                               int_accept,
  // Predivider taps and port A.
  input  wire logic [wake_timer_pkg::TAP_N-1:0]   tap_pin,
  input  wire logic [wake_timer_pkg::PA_W-1:0]    port_a_pin,
  input  wire logic [wake_timer_pkg::PA_W-1:0]    port_a_in_mode,
  // Read answer.
  output logic      [3:0]                         rd_data,
  output logic                                    rd_valid,
  // Mode and event outputs.
  output logic                                    halt_mode,
  output logic                                    stop_mode,
  output logic                                    op_refused,
  output logic                                    timer_underflow,
  output logic                                    timer_running,
  output logic                                    release_request_3,
  output logic                                    release_request_4
);
  import wake_timer_pkg::*;

  typedef struct packed {
    pwr_e             mode;
    logic [CNT_W-1:0] cnt;
    logic [SEL_W-1:0] sel;
    logic             run;
    logic             reload_en;
    logic             loaded;
    logic             carry_flag;
    logic             backup_flag;
    logic             halt_release_enable_3;
    logic             halt_release_enable_4;
    logic             sef5;
    logic             port_stop_release_enable;
    logic             req3;
    logic             req4;
    logic             port_wake_flag;
    logic             timer_wake_flag;
    logic             predivider_wake_flag;
    logic             stop_wake_flag;
    logic             uf;
    logic [3:0]       rd_data;
    logic             rd_valid;
    logic             refused;
  } state_s;

  state_s           s_r;
  state_s           s_nxt;
  logic [TAP_N-1:0] tap_lvl;
  logic [TAP_N-1:0] tap_rise;
  logic [PA_W-1:0]  pa_lvl;
  logic [PA_W-1:0]  pa_rise;
  logic [PA_W-1:0]  pa_fall;
  logic             tick;
  logic             uf_now;
  logic             is_load;
  logic [OPND_W-1:0] load_word;
  logic             any_scf;
  logic             port_change;
  logic             port_stop_request;

  // ****************************************************************
  // Synchronisers
  // ****************************************************************

  // Predivider taps come from the oscillator chain, not from mclk.
  edge_sync #(.WIDTH(TAP_N)) u_tap_sync (
    .mclk (mclk),
    .rst  (rst),
    .pin  (tap_pin),
    .lvl  (tap_lvl),
    .rise (tap_rise),
    .fall ()
  );

  // Port A arrives from the chatter filter in its own timing.
  edge_sync #(.WIDTH(PA_W)) u_pa_sync (
    .mclk (mclk),
    .rst  (rst),
    .pin  (port_a_pin),
    .lvl  (pa_lvl),
    .rise (pa_rise),
    .fall (pa_fall)
  );

  // ****************************************************************
  // Decodes
  // ****************************************************************

  // Tap selection; code 011 is unlisted and takes the fastest tap.
  always_comb begin
    unique case (s_r.sel)
      3'h0: tick = tap_rise[TAP9];
      3'h1: tick = tap_rise[TAP5];
      3'h2: tick = tap_rise[TAP15];
      3'h3: tick = tap_rise[TAP3];
      3'h4: tick = tap_rise[TAP5];
      3'h5: tick = tap_rise[TAP7];
      3'h6: tick = tap_rise[TAP11];
      3'h7: tick = tap_rise[TAP13];
    endcase
  end

  // Register-pair load packs accumulator above the working register.
  assign is_load = op_valid && (op_code == TIMER_LOAD_IMM_OP ||
                                op_code == TIMER_LOAD_REG_OP);
  assign load_word = (op_code == TIMER_LOAD_REG_OP) ?
                     {1'b0, acc_in, rx_in} : op_imm;
  // A load in the same cycle as a tick wins, so no underflow is seen.
  assign uf_now = s_r.run && tick && !is_load && s_r.cnt == CNT_ZERO;
  assign any_scf = s_r.port_wake_flag | s_r.timer_wake_flag |
                   s_r.predivider_wake_flag | s_r.stop_wake_flag;
  assign port_change = |((pa_rise | pa_fall) & port_a_in_mode);
  assign port_stop_request = |(pa_lvl & port_a_in_mode);

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Counter step and carry write apply first, then operations; hardware events after them so a set wins.
  always_comb begin
    s_nxt = s_r;
    s_nxt.uf = 1'b0;
    s_nxt.rd_valid = 1'b0;
    s_nxt.refused = 1'b0;
    // Tick phase is free running, so the first count may be short.
    if (s_r.run && tick && !is_load) begin
      s_nxt.cnt = s_r.cnt - 6'h01;
      if (uf_now) begin
        s_nxt.cnt = CNT_WRAP;
        s_nxt.uf = 1'b1;
        s_nxt.loaded = 1'b0;
        s_nxt.run = s_r.reload_en;
      end
    end
    if (alu_carry_we) begin
      s_nxt.carry_flag = alu_carry;
    end
    if (op_valid) begin
      unique case (op_code)
        TIMER_LOAD_IMM_OP, TIMER_LOAD_REG_OP: begin
          s_nxt.cnt = load_word[CNT_W-1:0];
          s_nxt.sel = load_word[SEL_LSB +: SEL_W];
          s_nxt.run = 1'b1;
          s_nxt.loaded = 1'b1;
        end
        RELOAD_ENABLE_OP: begin
          if (op_imm == OPND_RELOAD) begin
            s_nxt.reload_en = 1'b1;
            s_nxt.run = 1'b1;
          end
        end
        RELOAD_DISABLE_OP: begin
          if (op_imm == OPND_RELOAD) begin
            s_nxt.reload_en = 1'b0;
            if (!s_r.loaded || uf_now) begin
              s_nxt.run = 1'b0;
            end
          end
        end
        SET_FLAG_OP: begin
          if (op_imm == OPND_CARRY) begin
            s_nxt.carry_flag = 1'b1;
          end
          if (op_imm == OPND_BACKUP) begin
            s_nxt.backup_flag = 1'b1;
          end
        end
        CLEAR_FLAG_OP: begin
          if (op_imm == OPND_CARRY) begin
            s_nxt.carry_flag = 1'b0;
          end
          if (op_imm == OPND_BACKUP) begin
            s_nxt.backup_flag = 1'b0;
          end
        end
        READ_ARITH_STATUS_OP: begin
          s_nxt.rd_data = {s_r.carry_flag, acc_in == 4'h0, 2'b00};
          s_nxt.rd_valid = 1'b1;
        end
        WRITE_ARITH_STATUS_OP: begin
          s_nxt.carry_flag = ram_in[CF_BIT];
        end
        READ_BACKUP_STATUS_OP: begin
          s_nxt.rd_data = STATUS_RST;
          s_nxt.rd_data[NONPORT_BIT] = s_r.timer_wake_flag |
                                       s_r.predivider_wake_flag;
          s_nxt.rd_data[BACKUP_BIT] = s_r.backup_flag;
          s_nxt.rd_valid = 1'b1;
        end
        READ_PREDIVIDER_STATUS_OP: begin
          s_nxt.rd_data = STATUS_RST;
          s_nxt.rd_data[PDWAKE_BIT] = s_r.predivider_wake_flag;
          s_nxt.rd_data[TAP15_BIT] = tap_lvl[TAP15];
          s_nxt.rd_valid = 1'b1;
        end
        READ_WAKE_SOURCE_OP: begin
          s_nxt.rd_data = STATUS_RST;
          s_nxt.rd_data[PWAKE_BIT] = s_r.port_wake_flag;
          s_nxt.rd_data[TWAKE_BIT] = s_r.timer_wake_flag;
          s_nxt.rd_valid = 1'b1;
        end
        SWITCH_CONFIG_OP: begin
          s_nxt.sef5 = op_imm[SEF5_BIT];
          s_nxt.port_wake_flag = 1'b0;
        end
        HALT_RELEASE_CONFIG_OP: begin
          s_nxt.halt_release_enable_3 = op_imm[HALT_RELEASE_ENABLE_3_BIT];
          s_nxt.halt_release_enable_4 = op_imm[HALT_RELEASE_ENABLE_4_BIT];
          s_nxt.predivider_wake_flag = 1'b0;
          if (!op_imm[HALT_RELEASE_ENABLE_4_BIT]) begin
            s_nxt.timer_wake_flag = 1'b0;
          end
        end
        STOP_RELEASE_CONFIG_OP: begin
          s_nxt.port_stop_release_enable = op_imm[PORT_STOP_RELEASE_ENABLE_BIT];
        end
        CLEAR_REQUEST_OP: begin
          if (op_imm[REQ3_BIT]) begin
            s_nxt.req3 = 1'b0;
            s_nxt.predivider_wake_flag = 1'b0;
          end
          if (op_imm[REQ4_BIT]) begin
            s_nxt.req4 = 1'b0;
            s_nxt.timer_wake_flag = 1'b0;
          end
          if (op_imm[REQ_STOP_BIT]) begin
            s_nxt.stop_wake_flag = 1'b0;
          end
        end
        HALT_OP: begin
          if (s_r.mode == PWR_RUN && !any_scf) begin
            s_nxt.mode = PWR_HALT;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end
        STOP_OP: begin
          // Entry with a pin high would wake at once and bounce forever.
          if (s_r.mode == PWR_RUN && port_a_in_mode == PA_ALL_INPUT &&
              pa_lvl == '0 && !s_r.stop_wake_flag) begin
            s_nxt.mode = PWR_STOP;
            s_nxt.backup_flag = 1'b1;
          end else begin
            s_nxt.refused = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware events set their flags last.
    if (uf_now) begin
      s_nxt.req4 = 1'b1;
      if (s_r.halt_release_enable_4) begin
        s_nxt.timer_wake_flag = 1'b1;
      end
    end
    if (tap_rise[TAP15]) begin
      s_nxt.req3 = 1'b1;
      if (s_r.halt_release_enable_3) begin
        s_nxt.predivider_wake_flag = 1'b1;
      end
    end
    if (port_change && s_r.sef5 && s_r.mode != PWR_STOP) begin
      s_nxt.port_wake_flag = 1'b1;
    end
    // Power mode sequencing.
    unique case (s_r.mode)
      PWR_RUN: begin
      end
      PWR_HALT: begin
        if (any_scf || int_accept) begin
          s_nxt.mode = PWR_RUN;
        end
      end
      PWR_STOP: begin
        if (port_stop_request && s_r.port_stop_release_enable) begin
          s_nxt.stop_wake_flag = 1'b1;
          s_nxt.mode = PWR_HALT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Every output comes from the state register; the two mode outputs decode its mode field.
  assign rd_data = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;
  assign halt_mode = (s_r.mode == PWR_HALT);
  assign stop_mode = (s_r.mode == PWR_STOP);
  assign op_refused = s_r.refused;
  assign timer_underflow = s_r.uf;
  assign timer_running = s_r.run;
  assign release_request_3 = s_r.req3;
  assign release_request_4 = s_r.req4;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence seq_arith_read;
    op_valid && op_code == READ_ARITH_STATUS_OP;
  endsequence

  sequence seq_backup_read;
    op_valid && op_code == READ_BACKUP_STATUS_OP;
  endsequence

  chk_uf_stops: assert property (s_r.uf && !s_r.reload_en |-> !s_r.run)
    else $error("Timer kept running after underflow without reload.");
  chk_reload_keeps: assert property (s_r.uf && s_r.reload_en |-> s_r.run)
    else $error("Timer stopped on underflow with reload enabled.");
  chk_tick_step: assert property (s_r.run && tick && !op_valid &&
      s_r.cnt != CNT_ZERO |=> s_r.cnt == $past(s_r.cnt) - 6'h01)
    else $error("Timer did not step down on a tap edge.");
  chk_nil_read: assert property (seq_arith_read |=> rd_valid &&
      rd_data[NIL_BIT] == ($past(acc_in) == 4'h0))
    else $error("Accumulator-nil bit wrong.");
  chk_nonport_read: assert property (seq_backup_read |=> rd_valid &&
      rd_data[NONPORT_BIT] == $past(s_r.timer_wake_flag | s_r.predivider_wake_flag))
    else $error("Non-port wake bit wrong.");
  chk_halt_refuse: assert property (op_valid && op_code == HALT_OP && any_scf
      |=> op_refused && !halt_mode)
    else $error("Halt entered with a start condition flag set.");
  chk_backup_set: assert property (op_valid && op_code == SET_FLAG_OP &&
      op_imm == OPND_BACKUP |=> s_r.backup_flag)
    else $error("Backup flag not set.");
  chk_pd_wake: assert property (tap_rise[TAP15] && s_r.halt_release_enable_3
      |=> s_r.predivider_wake_flag && release_request_3)
    else $error("Predivider wake flag not set.");
  chk_timer_wake: assert property (uf_now && s_r.halt_release_enable_4
      |=> s_r.timer_wake_flag && release_request_4 && timer_underflow)
    else $error("Timer wake flag not set on underflow.");
  chk_stop_wake: assert property (stop_mode && port_stop_request && s_r.port_stop_release_enable
      |=> s_r.stop_wake_flag && halt_mode)
    else $error("Stop wake not taken.");
endmodule

// ==== core_model.sv ====
// Behavioural processor core that issues timer and status operations.
`timescale 1ns/1ns
module core_model (
  // Clock.
  input  wire logic                         mclk,
  // Operation strobe and operands.
  output logic                              op_valid,
  output wake_timer_pkg::op_e               op_code,
  output logic [wake_timer_pkg::OPND_W-1:0] op_imm,
  output logic [3:0]                        acc_in,
  output logic [3:0]                        rx_in,
  output logic [3:0]                        ram_in,
  // Carry from the arithmetic unit.
  output logic                              alu_carry_we,
  output logic                              alu_carry
);
  import wake_timer_pkg::*;
  // Expected read answers, oldest first.
  logic [3:0] exp_q[$];

  // ****************************************
  // Operation issue
  // ****************************************
  // Everything is quiet at time zero so the first edge sees no strobe.
  initial begin
    op_valid = 1'b0;
    op_code = NO_OP;
    op_imm = 9'h000;
    acc_in = 4'h0;
    rx_in = 4'h0;
    ram_in = 4'h0;
    alu_carry_we = 1'b0;
    alu_carry = 1'b0;
  end

  // One-cycle strobe; operands stay put afterwards since nil reads follow acc_in.
  task automatic issue(input op_e op, input logic [8:0] imm, input logic [3:0] acc,
                       input logic [3:0] rx, input logic [3:0] ram);
    @(posedge mclk);
    #1;
    op_valid = 1'b1;
    op_code = op;
    op_imm = imm;
    acc_in = acc;
    rx_in = rx;
    ram_in = ram;
    @(posedge mclk);
    #1;
    op_valid = 1'b0;
    op_code = NO_OP;
  endtask

  // A read notes its expected answer before the strobe goes out.
  task automatic rd(input op_e op, input logic [3:0] acc, input logic [3:0] exp);
    exp_q.push_back(exp);
    issue(op, 9'h000, acc, rx_in, ram_in);
  endtask

  // One-cycle carry write from the arithmetic unit.
  task automatic carry(input logic v);
    @(posedge mclk);
    #1;
    alu_carry_we = 1'b1;
    alu_carry = v;
    @(posedge mclk);
    #1;
    alu_carry_we = 1'b0;
  endtask
endmodule

// ==== interval_timer_wake_status_tb.sv ====
// Self-checking bench for the interval timer and wake status block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module interval_timer_wake_status_tb;
  import wake_timer_pkg::*;
  localparam int PER [8] = '{512, 32, 32768, 8, 32, 128, 2048, 8192};
  logic                       mclk;
  logic                       rst;
  logic                       op_valid;
  op_e                        op_code;
  logic [OPND_W-1:0]          op_imm;
  logic [3:0]                 acc_in;
  logic [3:0]                 rx_in;
  logic [3:0]                 ram_in;
  logic                       alu_carry_we;
  logic                       alu_carry;
  logic [PA_W-1:0]            port_a_in_mode;
  logic [PA_W-1:0]            port_a_pin;
  logic                       int_accept;
  logic [15:0]                div_cnt = 16'h0000;
  logic [3:0]                 rd_data;
  logic                       rd_valid;
  logic                       halt_mode;
  logic                       stop_mode;
  logic                       op_refused;
  logic                       timer_underflow;
  logic                       timer_running;
  logic                       release_request_3;
  logic                       release_request_4;
  logic [3:0]                 exp_v;
  logic [31:0]                lfsr;
  int                         num_errors = 0;
  int                         checked = 0;
  int                         cyc;

  // ****************************************
  // Clock, predivider and instances
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Predivider model: tap k toggles every 2^(k-1) oscillator periods.
  always @(posedge mclk) div_cnt <= #1 div_cnt + 16'h0001;

  wake_timer DUT (
    .mclk(mclk), .rst(rst), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .acc_in(acc_in), .rx_in(rx_in), .ram_in(ram_in), .alu_carry_we(alu_carry_we),
    .alu_carry(alu_carry), .int_accept(int_accept),
    .tap_pin({div_cnt[14], div_cnt[12], div_cnt[10], div_cnt[8], div_cnt[6], div_cnt[4],
              div_cnt[2]}),
    .port_a_pin(port_a_pin), .port_a_in_mode(port_a_in_mode), .rd_data(rd_data),
    .rd_valid(rd_valid), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .op_refused(op_refused), .timer_underflow(timer_underflow),
    .timer_running(timer_running), .release_request_3(release_request_3),
    .release_request_4(release_request_4));

  core_model core (
    .mclk(mclk), .op_valid(op_valid), .op_code(op_code), .op_imm(op_imm),
    .acc_in(acc_in), .rx_in(rx_in), .ram_in(ram_in), .alu_carry_we(alu_carry_we),
    .alu_carry(alu_carry));

  // Every read answer is matched against the oldest note mid-cycle, while it stands.
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) begin
      exp_v = (core.exp_q.size() > 0) ? core.exp_q.pop_front() : 4'hX;
      `CHK("rd_data", exp_v, rd_data)
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Arithmetic status read with a random accumulator, zero fairly often.
  task automatic rd_arith(input logic c);
    logic [3:0] a;
    lfsr = lfsr_next(lfsr);
    a = lfsr[3:0] & {4{lfsr[4]}};
    core.rd(READ_ARITH_STATUS_OP, a, {c, a == 4'h0, 2'b00});
  endtask

  // Waits for an underflow pulse under a bound, counting cycles.
  task automatic wait_uf(input int lim);
    cyc = 0;
    while (timer_underflow !== 1'b1 && cyc < lim) begin
      @(posedge mclk);
      #2;
      cyc++;
    end
  endtask

  // Drives port A just after an edge, then lets the synchroniser and wake settle.
  task automatic pa_set(input logic [PA_W-1:0] v);
    @(posedge mclk);
    #1;
    port_a_pin = v;
    repeat (6) @(posedge mclk);
    #1;
  endtask

  // Load and run to underflow; the interval must fall between n and n+1 ticks.
  task automatic run_timer(input logic [2:0] sel, input int n, input logic reg_load);
    int lo;
    int hi;
    if (reg_load) begin
      core.issue(TIMER_LOAD_REG_OP, 9'h000, {sel[1:0], 2'b00}, n[3:0], 4'h0);
    end else begin
      core.issue(TIMER_LOAD_IMM_OP, {sel, n[5:0]}, 4'h0, 4'h0, 4'h0);
    end
    `CHK("timer_running", 1'b1, timer_running)
    wait_uf((n + 1) * PER[sel] + 50);
    lo = n * PER[sel];
    hi = (n + 1) * PER[sel] + 4;
    `CHK("interval", 1'b1, cyc >= lo && cyc <= hi)
    `CHK("release_request_4", 1'b1, release_request_4)
    `CHK("timer_running", 1'b0, timer_running)
  endtask

  task automatic end_of_test;
    // A read that never answered leaves its note behind.
    `CHK("pending_reads", 0, core.exp_q.size())
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    port_a_in_mode = 4'h0;
    port_a_pin = 4'h0;
    int_accept = 1'b0;
    lfsr = 32'h114B;
    repeat (20) @(posedge mclk);
    #1 rst = 1'b0;
    // Carry flag through set, arithmetic unit and status write, nil flag on random accumulators.
    rd_arith(1'b0);
    core.issue(SET_FLAG_OP, OPND_CARRY, 4'h1, 4'h0, 4'h0);
    rd_arith(1'b1);
    core.carry(1'b0);
    rd_arith(1'b0);
    core.issue(WRITE_ARITH_STATUS_OP, 9'h000, 4'h0, 4'h0, 4'h8);
    rd_arith(1'b1);
    // Backup flag set and clear.
    core.issue(SET_FLAG_OP, OPND_BACKUP, 4'h0, 4'h0, 4'h0);
    core.rd(READ_BACKUP_STATUS_OP, 4'h0, 4'h1);
    core.issue(CLEAR_FLAG_OP, OPND_BACKUP, 4'h0, 4'h0, 4'h0);
    core.rd(READ_BACKUP_STATUS_OP, 4'h0, 4'h0);
    // Stop is refused while port A is not all input.
    core.issue(STOP_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("op_refused", 1'b1, op_refused)
    // Every clock select but 010, one through the register-pair load.
    core.issue(HALT_RELEASE_CONFIG_OP, 9'h010, 4'h0, 4'h0, 4'h0);
    for (int k = 0; k < 8; k++) begin
      if (k != 2) begin
        core.issue(CLEAR_REQUEST_OP, 9'h010, 4'h0, 4'h0, 4'h0);
        run_timer(k[2:0], 1, k == 1);
      end
    end
    core.rd(READ_WAKE_SOURCE_OP, 4'h0, 4'h2);
    core.rd(READ_BACKUP_STATUS_OP, 4'h0, 4'h4);
    core.issue(HALT_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("op_refused", 1'b1, op_refused)
    core.issue(CLEAR_REQUEST_OP, 9'h010, 4'h0, 4'h0, 4'h0);
    `CHK("release_request_4", 1'b0, release_request_4)
    core.rd(READ_WAKE_SOURCE_OP, 4'h0, 4'h0);
    // Reload: wrong operand ignored, then counting resumes from 3F and survives underflow.
    run_timer(3'b011, 1, 1'b0);
    core.issue(RELOAD_ENABLE_OP, 9'h002, 4'h0, 4'h0, 4'h0);
    `CHK("timer_running", 1'b0, timer_running)
    core.issue(RELOAD_ENABLE_OP, OPND_RELOAD, 4'h0, 4'h0, 4'h0);
    `CHK("timer_running", 1'b1, timer_running)
    wait_uf(600);
    `CHK("reload_interval", 1'b1, cyc >= 63 * 8 && cyc <= 64 * 8 + 4)
    @(posedge mclk);
    #2;
    `CHK("timer_running", 1'b1, timer_running)
    core.issue(RELOAD_DISABLE_OP, OPND_RELOAD, 4'h0, 4'h0, 4'h0);
    `CHK("timer_running", 1'b0, timer_running)
    // Slowest tap with predivider wake armed beforehand.
    core.issue(HALT_RELEASE_CONFIG_OP, 9'h018, 4'h0, 4'h0, 4'h0);
    core.issue(CLEAR_REQUEST_OP, 9'h018, 4'h0, 4'h0, 4'h0);
    run_timer(3'b010, 0, 1'b0);
    core.rd(READ_PREDIVIDER_STATUS_OP, 4'h0, 4'hC);
    `CHK("release_request_3", 1'b1, release_request_3)
    core.issue(CLEAR_REQUEST_OP, 9'h008, 4'h0, 4'h0, 4'h0);
    core.rd(READ_PREDIVIDER_STATUS_OP, 4'h0, 4'h4);
    // Port wake leaves halt; a high input pin wakes stop, which passes through halt.
    core.issue(HALT_RELEASE_CONFIG_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    core.issue(CLEAR_REQUEST_OP, 9'h019, 4'h0, 4'h0, 4'h0);
    port_a_in_mode = 4'hF;
    core.issue(SWITCH_CONFIG_OP, 9'h020, 4'h0, 4'h0, 4'h0);
    core.issue(HALT_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("halt_mode", 1'b1, halt_mode)
    pa_set(4'h1);
    `CHK("halt_mode", 1'b0, halt_mode)
    pa_set(4'h0);
    core.rd(READ_WAKE_SOURCE_OP, 4'h0, 4'h4);
    core.issue(SWITCH_CONFIG_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    core.rd(READ_WAKE_SOURCE_OP, 4'h0, 4'h0);
    core.issue(STOP_RELEASE_CONFIG_OP, 9'h040, 4'h0, 4'h0, 4'h0);
    core.issue(STOP_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("stop_mode", 1'b1, stop_mode)
    pa_set(4'h2);
    `CHK("stop_mode", 1'b0, stop_mode)
    `CHK("halt_mode", 1'b0, halt_mode)
    core.issue(HALT_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("op_refused", 1'b1, op_refused)
    core.rd(READ_BACKUP_STATUS_OP, 4'h0, 4'h1);
    core.issue(CLEAR_REQUEST_OP, 9'h001, 4'h0, 4'h0, 4'h0);
    pa_set(4'h0);
    core.issue(HALT_OP, 9'h000, 4'h0, 4'h0, 4'h0);
    `CHK("halt_mode", 1'b1, halt_mode)
    @(posedge mclk);
    #1;
    int_accept = 1'b1;
    @(posedge mclk);
    #1;
    int_accept = 1'b0;
    `CHK("halt_mode", 1'b0, halt_mode)
    repeat (3) @(posedge mclk);
    end_of_test();
  end
endmodule
